// *** core/sysref_pulser_delay_ctrl.sv ***
// pulse burst, feedback select, power-down and dynamic delay registers
// assumes source select, sync mode and disable modes come from neighbours
`include "sysref_pulser_cfg.svh"
`default_nettype none

// Overview of operation
// - writing burst length launches a burst if pulser selected and powered and sync mode is 3
// - burst code 0,1,2,3 gives 1,2,4,8 pulses; resets to 3
// - continuous source ignores the burst count entirely
// - synthesis loop n-divider source: 0 prescaler, 1 feedback mux
// - cleaner loop n-delay source: 0 oscillator input, 1 feedback mux
// - feedback source: output 6, output 8, frame ref divider, external
// - feedback power-on bit: 0 powers mux down; host sets it for zero delay
// - bits 7..4 power down cleaner loop, vco regulator, vco, osc input
// - global bit powers down each frame ref output per its disable mode
// - frame ref power-down, reset 1, stops frame ref outputs and sync
// - delay power-down resets to 1; host clears it during sync
// - pulse generator power-down, reset 1, holds the pulser off
// - enable bit 7 is frame ref, bits 6..0 outputs 12,10,8,6,4,2,0
// - writing step count in sync mode 3 starts adjustment on every enabled output
// - step count 1 to 15 gives that many steps; 0 does nothing
// - only a serial write of step count starts adjustment
// - source 2 selects the pulser, 3 continuous frame ref
// - sync mode 3 makes a burst length write emit pulses
module sysref_pulser_delay_ctrl #(
	parameter int unsigned PULSE_HIGH = `PULSE_HIGH_CYCLES,
	parameter int unsigned PULSE_LOW  = `PULSE_LOW_CYCLES,
	parameter int unsigned STEP_GAP   = `STEP_GAP_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        spiCsN,
	input  wire logic        spiSclk,
	input  wire logic        spiSdi,
	output logic             spiSdo,
	output logic             spiSdoOeN,
	input  wire logic [1:0]  frameRefSourceSelect,
	input  wire logic [1:0]  syncMode,
	input  wire logic [13:0] perOutputDisableMode,
	output logic             frameRefPulse,
	output logic             burstActive,
	output logic             synthLoopNdivSource,
	output logic             cleanerLoopNdelaySource,
	output logic [1:0]       feedbackSourceSelect,
	output logic             feedbackSelectPowerOn,
	output logic             cleanerLoopPowerDown,
	output logic             vcoRegulatorPowerDown,
	output logic             vcoPowerDown,
	output logic             oscInputPowerDown,
	output logic [6:0]       frameRefOutputPowerDown,
	output logic             frameRefPowerDown,
	output logic             syncAvailable,
	output logic             frameRefDelayPowerDown,
	output logic             pulseGeneratorPowerDown,
	output logic             frameRefDynDelayEnable,
	output logic [6:0]       outputDynDelayEnable,
	output logic             dynDelayStep,
	output logic [7:0]       dynDelayTargets,
	output logic [3:0]       dynStepsRemaining
);
	// ************************************************************
	// serial port and register file
	// ************************************************************
	sysref_pulser_pkg::reg_addr_t regAddr;
	sysref_pulser_pkg::reg_data_t wrData;
	sysref_pulser_pkg::reg_data_t rdData;
	logic                         wrStrobe;
	logic [7:0]                   burstLength;
	logic [7:0]                   feedbackSelect;
	logic [7:0]                   powerDownCtl;
	logic [7:0]                   dynEnables;
	logic [7:0]                   dynSteps;
	logic                         burstWrite;
	logic                         stepWrite;

	spi_frame_port u_port (
		.clk       (clk),
		.reset     (reset),
		.spiCsN    (spiCsN),
		.spiSclk   (spiSclk),
		.spiSdi    (spiSdi),
		.rdData    (rdData),
		.spiSdo    (spiSdo),
		.spiSdoOeN (spiSdoOeN),
		.wrStrobe  (wrStrobe),
		.regAddr   (regAddr),
		.wrData    (wrData)
	);

	// register readback; unmapped and reserved bits read zero
	function automatic logic [7:0] readReg(input logic [12:0] a);
		case (a)
			`OFF_BURST_LENGTH:    readReg = burstLength;
			`OFF_FEEDBACK_SELECT: readReg = feedbackSelect;
			`OFF_POWER_DOWN:      readReg = powerDownCtl;
			`OFF_DYN_ENABLES:     readReg = dynEnables;
			`OFF_DYN_STEPS:       readReg = dynSteps;
			default:              readReg = 8'h00;
		endcase
	endfunction

	assign rdData     = readReg(regAddr);
	assign burstWrite = wrStrobe && regAddr == `OFF_BURST_LENGTH;
	assign stepWrite  = wrStrobe && regAddr == `OFF_DYN_STEPS;

	// burst length code, reserved bits masked on write
	always_ff @(posedge clk) begin
		if (reset) begin
			burstLength <= `RST_BURST_LENGTH;
		end else if (burstWrite) begin
			burstLength <= wrData & `MASK_BURST_LENGTH;
		end
	end

	// feedback path selects
	always_ff @(posedge clk) begin
		if (reset) begin
			feedbackSelect <= `RST_FEEDBACK_SELECT;
		end else if (wrStrobe && regAddr == `OFF_FEEDBACK_SELECT) begin
			feedbackSelect <= wrData & `MASK_FEEDBACK_SELECT;
		end
	end

	// power-down controls; frame ref, delay and pulser start powered down
	always_ff @(posedge clk) begin
		if (reset) begin
			powerDownCtl <= `RST_POWER_DOWN;
		end else if (wrStrobe && regAddr == `OFF_POWER_DOWN) begin
			powerDownCtl <= wrData & `MASK_POWER_DOWN;
		end
	end

	// dynamic delay enables
	always_ff @(posedge clk) begin
		if (reset) begin
			dynEnables <= `RST_DYN_ENABLES;
		end else if (wrStrobe && regAddr == `OFF_DYN_ENABLES) begin
			dynEnables <= wrData & `MASK_DYN_ENABLES;
		end
	end

	// dynamic delay step count
	always_ff @(posedge clk) begin
		if (reset) begin
			dynSteps <= `RST_DYN_STEPS;
		end else if (stepWrite) begin
			dynSteps <= wrData & `MASK_DYN_STEPS;
		end
	end

	// ************************************************************
	// static control outputs
	// ************************************************************
	// feedback mux and loop input routing
	assign synthLoopNdivSource     = feedbackSelect[`POS_SYNTH_NDIV_SRC];
	assign cleanerLoopNdelaySource = feedbackSelect[`POS_CLEANER_NDLY_SRC];
	assign feedbackSourceSelect    =
		feedbackSelect[`POS_FB_SRC_HI:`POS_FB_SRC_LO];
	assign feedbackSelectPowerOn   = feedbackSelect[`POS_FB_POWER_ON];

	// loop and oscillator power-down, active high
	assign cleanerLoopPowerDown  = powerDownCtl[`POS_CLEANER_PD];
	assign vcoRegulatorPowerDown = powerDownCtl[`POS_VCO_REG_PD];
	assign vcoPowerDown          = powerDownCtl[`POS_VCO_POWER_DOWN];
	assign oscInputPowerDown     = powerDownCtl[`POS_OSC_IN_PD];

	// frame ref power-down; sync is unavailable while it is set
	assign frameRefPowerDown       = powerDownCtl[`POS_FR_PD];
	assign syncAvailable           = ~powerDownCtl[`POS_FR_PD];
	assign frameRefDelayPowerDown  = powerDownCtl[`POS_FR_DELAY_PD];
	assign pulseGeneratorPowerDown = powerDownCtl[`POS_PULSE_GEN_PD];

	// one global bit fans out; a zero disable mode keeps that output alive
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_gbl_pd
			assign frameRefOutputPowerDown[gi] =
				powerDownCtl[`POS_GLOBAL_FR_PD] &&
				perOutputDisableMode[2*gi+1 -: 2] != 2'h0;
		end
	endgenerate

	// enable bit 7 is frame ref, 6..0 map to outputs 12 down to 0
	assign frameRefDynDelayEnable = dynEnables[`POS_FR_DYN_ENABLE];
	assign outputDynDelayEnable   = dynEnables[6:0];

	// ************************************************************
	// pulse burst generator
	// ************************************************************
	sysref_pulser_pkg::burst_state_e burstState;
	logic [7:0]                      burstTimer;
	logic [3:0]                      pulsesLeft;
	logic                            pulserReady;
	logic                            burstLaunch;

	// burst length from the two-bit code
	function automatic logic [3:0] pulsesFor(input logic [1:0] code);
		pulsesFor = 4'h1 << code;
	endfunction

	// pulser must be selected, not continuous, and both supplies up
	assign pulserReady =
		frameRefSourceSelect == `SRC_PULSER &&
		!powerDownCtl[`POS_FR_PD] &&
		!powerDownCtl[`POS_PULSE_GEN_PD] &&
		syncMode == `SYNC_MODE_ON_WRITE;
	assign burstLaunch = burstWrite && pulserReady;

	// a write during a burst restarts it with the new length
	always_ff @(posedge clk) begin
		if (reset) begin
			burstState <= sysref_pulser_pkg::BURST_IDLE;
			burstTimer <= 8'h00;
			pulsesLeft <= 4'h0;
		end else if (burstLaunch) begin
			burstState <= sysref_pulser_pkg::BURST_HIGH;
			burstTimer <= 8'(PULSE_HIGH - 1);
			pulsesLeft <= pulsesFor(wrData[1:0]);
		end else if (!pulserReady) begin
			// power-down or source change aborts a running burst
			burstState <= sysref_pulser_pkg::BURST_IDLE;
			pulsesLeft <= 4'h0;
		end else begin
			case (burstState)
				sysref_pulser_pkg::BURST_IDLE: begin
					burstTimer <= 8'h00;
				end
				sysref_pulser_pkg::BURST_HIGH: begin
					if (burstTimer != 8'h00) begin
						burstTimer <= burstTimer - 8'h01;
					end else if (pulsesLeft == 4'h1) begin
						pulsesLeft <= 4'h0;
						burstState <= sysref_pulser_pkg::BURST_IDLE;
					end else begin
						pulsesLeft <= pulsesLeft - 4'h1;
						burstTimer <= 8'(PULSE_LOW - 1);
						burstState <= sysref_pulser_pkg::BURST_LOW;
					end
				end
				sysref_pulser_pkg::BURST_LOW: begin
					if (burstTimer != 8'h00) begin
						burstTimer <= burstTimer - 8'h01;
					end else begin
						burstTimer <= 8'(PULSE_HIGH - 1);
						burstState <= sysref_pulser_pkg::BURST_HIGH;
					end
				end
				default: begin
					burstState <= sysref_pulser_pkg::BURST_IDLE;
				end
			endcase
		end
	end

	assign frameRefPulse = burstState[1];
	assign burstActive   = ~burstState[0];

	// ************************************************************
	// dynamic delay step sequencer
	// ************************************************************
	sysref_pulser_pkg::delay_state_e delayState;
	logic [7:0]                      gapTimer;
	logic                            delayStart;

	// only the serial write starts it; zero steps means no adjustment
	assign delayStart = stepWrite && wrData[3:0] != 4'h0 &&
		syncMode == `SYNC_MODE_ON_WRITE;

	// one step pulse per requested step, targets latched at start
	always_ff @(posedge clk) begin
		if (reset) begin
			delayState        <= sysref_pulser_pkg::DELAY_IDLE;
			gapTimer          <= 8'h00;
			dynStepsRemaining <= 4'h0;
			dynDelayTargets   <= 8'h00;
		end else if (delayStart) begin
			delayState        <= sysref_pulser_pkg::DELAY_STEP;
			dynStepsRemaining <= wrData[3:0];
			dynDelayTargets   <= dynEnables;
		end else begin
			case (delayState)
				sysref_pulser_pkg::DELAY_IDLE: begin
					gapTimer <= 8'h00;
				end
				sysref_pulser_pkg::DELAY_STEP: begin
					dynStepsRemaining <= dynStepsRemaining - 4'h1;
					if (dynStepsRemaining == 4'h1) begin
						delayState <= sysref_pulser_pkg::DELAY_IDLE;
					end else begin
						gapTimer   <= 8'(STEP_GAP - 1);
						delayState <= sysref_pulser_pkg::DELAY_GAP;
					end
				end
				sysref_pulser_pkg::DELAY_GAP: begin
					if (gapTimer != 8'h00) begin
						gapTimer <= gapTimer - 8'h01;
					end else begin
						delayState <= sysref_pulser_pkg::DELAY_STEP;
					end
				end
				default: begin
					delayState <= sysref_pulser_pkg::DELAY_IDLE;
				end
			endcase
		end
	end

	assign dynDelayStep = delayState[1];

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_launch;
		burstWrite && pulserReady;
	endsequence

	sequence s_first_pulse;
		frameRefPulse [*2];
	endsequence

	property p_burst_launch;
		s_launch |=> s_first_pulse;
	endproperty
	a_burst_launch: assert property (p_burst_launch)
		else $error("burst did not start after length write");

	property p_burst_count;
		s_launch |=> pulsesLeft == (4'h1 << $past(wrData[1:0]));
	endproperty
	a_burst_count: assert property (p_burst_count)
		else $error("burst pulse count wrong");

	property p_no_burst_continuous;
		frameRefSourceSelect == `SRC_CONTINUOUS |=> !frameRefPulse;
	endproperty
	a_no_burst_continuous: assert property (p_no_burst_continuous)
		else $error("pulse emitted in continuous mode");

	property p_pulser_held_off;
		powerDownCtl[`POS_PULSE_GEN_PD] |=> burstState[0];
	endproperty
	a_pulser_held_off: assert property (p_pulser_held_off)
		else $error("pulser active while powered down");

	property p_sync_blocked;
		wrStrobe && regAddr == `OFF_POWER_DOWN |=>
			syncAvailable == !$past(wrData[`POS_FR_PD]);
	endproperty
	a_sync_blocked: assert property (p_sync_blocked)
		else $error("sync available while frame ref powered down");

	property p_step_start;
		delayStart |=> dynDelayStep && dynDelayTargets == $past(dynEnables);
	endproperty
	a_step_start: assert property (p_step_start)
		else $error("delay adjustment did not start");

	property p_zero_steps;
		stepWrite && wrData[3:0] == 4'h0 && delayState[0] |=> delayState[0];
	endproperty
	a_zero_steps: assert property (p_zero_steps)
		else $error("zero step count started adjustment");

	property p_only_serial_start;
		delayState[0] && !stepWrite |=> delayState[0];
	endproperty
	a_only_serial_start: assert property (p_only_serial_start)
		else $error("delay adjustment started without a write");

	property p_reserved_zero;
		(burstLength[7:2] == 6'h00) && (feedbackSelect[7:5] == 3'h0) &&
		(dynSteps[7:4] == 4'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits not zero");

	property p_fb_route;
		wrStrobe && regAddr == `OFF_FEEDBACK_SELECT |=>
			synthLoopNdivSource == $past(wrData[4]) &&
			cleanerLoopNdelaySource == $past(wrData[3]);
	endproperty
	a_fb_route: assert property (p_fb_route)
		else $error("loop input select did not follow write");
endmodule

`default_nettype wire

// *** core/sysref_pulser_cfg.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 13-bit register address and 8-bit register data
`ifndef SYSREF_PULSER_CFG_SVH
`define SYSREF_PULSER_CFG_SVH

// register offsets
`define OFF_BURST_LENGTH    13'h013E
`define OFF_FEEDBACK_SELECT 13'h013F
`define OFF_POWER_DOWN      13'h0140
`define OFF_DYN_ENABLES     13'h0141
`define OFF_DYN_STEPS       13'h0142

// reset values
`define RST_BURST_LENGTH    8'h03
`define RST_FEEDBACK_SELECT 8'h00
`define RST_POWER_DOWN      8'h07
`define RST_DYN_ENABLES     8'h00
`define RST_DYN_STEPS       8'h00

// writable bits; the rest are reserved and read as zero
`define MASK_BURST_LENGTH    8'h03
`define MASK_FEEDBACK_SELECT 8'h1F
`define MASK_POWER_DOWN      8'hFF
`define MASK_DYN_ENABLES     8'hFF
`define MASK_DYN_STEPS       8'h0F

// field positions
`define POS_SYNTH_NDIV_SRC    4
`define POS_CLEANER_NDLY_SRC  3
`define POS_FB_SRC_HI         2
`define POS_FB_SRC_LO         1
`define POS_FB_POWER_ON       0
`define POS_CLEANER_PD        7
`define POS_VCO_REG_PD        6
`define POS_VCO_POWER_DOWN            5
`define POS_OSC_IN_PD         4
`define POS_GLOBAL_FR_PD      3
`define POS_FR_PD             2
`define POS_FR_DELAY_PD       1
`define POS_PULSE_GEN_PD      0
`define POS_FR_DYN_ENABLE     7

// source and mode codes
`define SRC_PULSER          2'h2
`define SRC_CONTINUOUS      2'h3
`define SYNC_MODE_ON_WRITE  2'h3

// timing counts in clock cycles
`define PULSE_HIGH_CYCLES   4
`define PULSE_LOW_CYCLES    4
`define STEP_GAP_CYCLES     8

`endif

// *** core/sysref_pulser_pkg.sv ***
// types shared by the pulser and delay control block
// assumes the cfg header provides all numeric constants
`default_nettype none

package sysref_pulser_pkg;
	typedef logic [12:0] reg_addr_t;
	typedef logic [7:0]  reg_data_t;

	// burst generator states, one-hot
	typedef enum logic [2:0] {
		BURST_IDLE = 3'b001,
		BURST_HIGH = 3'b010,
		BURST_LOW  = 3'b100
	} burst_state_e;

	// delay step sequencer states, one-hot
	typedef enum logic [2:0] {
		DELAY_IDLE = 3'b001,
		DELAY_STEP = 3'b010,
		DELAY_GAP  = 3'b100
	} delay_state_e;
endpackage

`default_nettype wire

// *** core/spi_frame_port.sv ***
// serial register port: 24-bit frames, read/write bit, 13-bit address, data
// assumes the serial pins are synchronous to clk and sclk is much slower
`default_nettype none

module spi_frame_port (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic                       spiCsN,
	input  wire logic                       spiSclk,
	input  wire logic                       spiSdi,
	input  wire sysref_pulser_pkg::reg_data_t rdData,
	output logic                            spiSdo,
	output logic                            spiSdoOeN,
	output logic                            wrStrobe,
	output sysref_pulser_pkg::reg_addr_t    regAddr,
	output sysref_pulser_pkg::reg_data_t    wrData
);
	logic        sclkPrev;
	logic [4:0]  bitCount;
	logic [22:0] shiftIn;
	logic        isRead;
	logic [7:0]  shiftOut;
	logic        sclkRise;
	logic        sclkFall;
	logic        inFrame;

	assign sclkRise = spiSclk & ~sclkPrev;
	assign sclkFall = ~spiSclk & sclkPrev;
	assign inFrame  = ~spiCsN & (bitCount < 5'd24);

	// edge detection on the serial clock
	always_ff @(posedge clk) begin
		sclkPrev <= reset ? 1'b0 : spiSclk;
	end

	// bit counter, restarted whenever chip select is released
	always_ff @(posedge clk) begin
		if (reset || spiCsN) begin
			bitCount <= 5'd0;
		end else if (sclkRise && inFrame) begin
			bitCount <= bitCount + 5'd1;
		end
	end

	// incoming shift register and read flag
	always_ff @(posedge clk) begin
		if (reset || spiCsN) begin
			shiftIn <= 23'h0;
			isRead  <= 1'b0;
		end else if (sclkRise && inFrame) begin
			shiftIn <= {shiftIn[21:0], spiSdi};
			if (bitCount == 5'd0) begin
				isRead <= spiSdi;
			end
		end
	end

	// address is complete on the sixteenth bit
	always_ff @(posedge clk) begin
		if (reset) begin
			regAddr <= 13'h0000;
		end else if (sclkRise && inFrame && bitCount == 5'd15) begin
			regAddr <= {shiftIn[11:0], spiSdi};
		end
	end

	// write strobe only on a full frame; a short frame writes nothing
	always_ff @(posedge clk) begin
		if (reset) begin
			wrStrobe <= 1'b0;
			wrData   <= 8'h00;
		end else begin
			wrStrobe <= sclkRise && inFrame && bitCount == 5'd23 && !isRead;
			if (sclkRise && inFrame && bitCount == 5'd23) begin
				wrData <= {shiftIn[6:0], spiSdi};
			end
		end
	end

	// read data shifted out on falling edges, msb first
	always_ff @(posedge clk) begin
		if (reset) begin
			shiftOut <= 8'h00;
		end else if (sclkFall && isRead && bitCount == 5'd16) begin
			shiftOut <= rdData;
		end else if (sclkFall && isRead && bitCount > 5'd16) begin
			shiftOut <= {shiftOut[6:0], 1'b0};
		end
	end

	assign spiSdo    = shiftOut[7];
	assign spiSdoOeN = ~(~spiCsN & isRead & (bitCount >= 5'd16));
endmodule

`default_nettype wire

// *** verif/spi_host_model.sv ***
// serial host model: whole 24-bit register frames, read or write
// assumes the device samples the serial pins with clk
`default_nettype none

module spi_host_model (
	input  wire logic clk,
	input  wire logic spiSdo,
	input  wire logic spiSdoOeN,
	output logic      spiCsN,
	output logic      spiSclk,
	output logic      spiSdi
);
	timeunit 1ns;
	timeprecision 100ps;

	logic sdoLast;
	logic sdoWire;

	// a released read line shows the inverse of its last driven bit
	always @(posedge clk) begin
		if (!spiSdoOeN) sdoLast <= spiSdo;
	end
	assign sdoWire = spiSdoOeN ? ~sdoLast : spiSdo;

	// serial clock stands low between frames
	initial begin
		spiCsN = 1'b1;
		spiSclk = 1'b0;
		spiSdi = 1'b0;
	end

	// low phase of 3 clk leaves room for the registered read bit
	task automatic frame(input logic rd,
		input sysref_pulser_pkg::reg_addr_t addr,
		input sysref_pulser_pkg::reg_data_t wd,
		output sysref_pulser_pkg::reg_data_t q);
		logic [23:0] word;
		word = {rd, 2'b00, addr, wd};
		q = 8'h00;
		@(negedge clk);
		spiCsN = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spiSclk = 1'b0;
			spiSdi = word[i];
			repeat (3) @(negedge clk);
			if (i < 8) q = {q[6:0], sdoWire};
			spiSclk = 1'b1;
			repeat (2) @(negedge clk);
		end
		spiSclk = 1'b0;
		repeat (2) @(negedge clk);
		spiCsN = 1'b1;
		spiSdi = ~spiSdi;
	endtask
endmodule

`default_nettype wire

// *** verif/sysref_pulser_delay_ctrl_tb.sv ***
// self-checking bench for the pulser and delay control registers
// assumes the serial host model and the cfg header are compiled with it
`include "sysref_pulser_cfg.svh"
`default_nettype none

module sysref_pulser_delay_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, reset, spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOeN;
	logic [1:0] srcSel, syncMode, fbSel;
	logic [13:0] disMode;
	logic frameRefPulse, burstActive, synthSrc, cleanerSrc, fbOn;
	logic cleanerPd, vcoRegPd, vcoPd, oscPd, frPd, syncAvail, frDlyPd;
	logic plsPd, frDynEn, dynStep, clrCnt, prevPulse;
	logic [6:0] outPd, outDynEn;
	logic [7:0] dynTargets, q;
	logic [3:0] stepsLeft;
	logic [15:0] pulseRises, pulseHighs, stepCount, errCount, numChecks;
	logic [7:0] rstTab [6] = '{8'h03, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
	logic [7:0] maskTab [6] = '{8'h03, 8'h1F, 8'hFF, 8'hFF, 8'h0F, 8'h00};
	logic [1:0] badSrc [3] = '{2'h3, 2'h2, 2'h2};
	logic [7:0] badPd [3] = '{8'hA0, 8'hA4, 8'hA1};
	logic [3:0] stepTab [3] = '{4'h0, 4'h1, 4'hF};

	sysref_pulser_delay_ctrl dut (.clk(clk), .reset(reset),
		.spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdi(spiSdi),
		.spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN),
		.frameRefSourceSelect(srcSel), .syncMode(syncMode),
		.perOutputDisableMode(disMode), .frameRefPulse(frameRefPulse),
		.burstActive(burstActive), .synthLoopNdivSource(synthSrc),
		.cleanerLoopNdelaySource(cleanerSrc), .feedbackSourceSelect(fbSel),
		.feedbackSelectPowerOn(fbOn), .cleanerLoopPowerDown(cleanerPd),
		.vcoRegulatorPowerDown(vcoRegPd), .vcoPowerDown(vcoPd),
		.oscInputPowerDown(oscPd), .frameRefOutputPowerDown(outPd),
		.frameRefPowerDown(frPd), .syncAvailable(syncAvail),
		.frameRefDelayPowerDown(frDlyPd), .pulseGeneratorPowerDown(plsPd),
		.frameRefDynDelayEnable(frDynEn), .outputDynDelayEnable(outDynEn),
		.dynDelayStep(dynStep), .dynDelayTargets(dynTargets),
		.dynStepsRemaining(stepsLeft));

	spi_host_model host (.clk(clk), .spiSdo(spiSdo),
		.spiSdoOeN(spiSdoOeN), .spiCsN(spiCsN), .spiSclk(spiSclk),
		.spiSdi(spiSdi));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// counts pulse rises, pulse-high cycles and delay steps
	always @(posedge clk) begin
		prevPulse <= frameRefPulse;
		if (clrCnt) begin
			pulseRises <= 16'h0000;
			pulseHighs <= 16'h0000;
			stepCount <= 16'h0000;
		end else begin
			pulseRises <= pulseRises + 16'(frameRefPulse && !prevPulse);
			pulseHighs <= pulseHighs + 16'(frameRefPulse);
			stepCount <= stepCount + 16'(dynStep);
		end
	end

	// ****************
	// helper tasks
	// ****************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic giveVerdict();
		$display("checks %0d errors %0d", numChecks, errCount);
		if (errCount == 16'h0000 && numChecks > 16'h0000) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// a write frame, then room for a launched sequence to start
	task automatic wr(input sysref_pulser_pkg::reg_addr_t a,
		input sysref_pulser_pkg::reg_data_t d);
		sysref_pulser_pkg::reg_data_t r;
		clrCnt = 1'b0;
		host.frame(1'b0, a, d, r);
		repeat (4) @(negedge clk);
	endtask

	// bounded wait until burst and step sequencers are idle
	task automatic settle();
		int n;
		n = 0;
		while ((burstActive !== 1'b0 || stepsLeft !== 4'h0) && n < 600) begin
			@(negedge clk);
			n++;
		end
		if (n >= 600) begin
			errCount++;
			giveVerdict();
		end else begin
			repeat (2) @(negedge clk);
		end
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		errCount = 16'h0000;
		numChecks = 16'h0000;
		reset = 1'b1;
		clrCnt = 1'b1;
		srcSel = 2'h0;
		syncMode = 2'h0;
		disMode = 14'b00_01_10_11_00_01_00;
		repeat (16) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		check({frPd, syncAvail}, 16'h0002);
		check({frDlyPd, plsPd}, 16'h0003);
		// reset values, the sixth place is unmapped
		for (int i = 0; i < 6; i++) begin
			host.frame(1'b1, 13'(`OFF_BURST_LENGTH + i), 8'h00, q);
			check(q, rstTab[i]);
		end
		// all ones everywhere: reserved bits must stay clear
		for (int i = 0; i < 6; i++) begin
			wr(13'(`OFF_BURST_LENGTH + i), 8'hFF);
			host.frame(1'b1, 13'(`OFF_BURST_LENGTH + i), 8'h00, q);
			check(q, maskTab[i]);
		end
		check({synthSrc, cleanerSrc, fbSel, fbOn}, 16'h001F);
		check({cleanerPd, vcoRegPd, vcoPd, oscPd}, 16'h000F);
		check(outPd, 16'h003A);
		check({frDynEn, outDynEn}, 16'h00FF);
		wr(`OFF_POWER_DOWN, 8'hF7);
		check(outPd, 16'h0000);
		// field mapping with uneven patterns
		wr(`OFF_FEEDBACK_SELECT, 8'h0A);
		check({synthSrc, cleanerSrc}, 16'h0001);
		check({fbSel, fbOn}, 16'h0002);
		wr(`OFF_FEEDBACK_SELECT, 8'h15); // zero delay on
		check({synthSrc, cleanerSrc}, 16'h0002);
		check({fbSel, fbOn}, 16'h0005);
		wr(`OFF_POWER_DOWN, 8'hA0); // delay logic up
		check({cleanerPd, vcoRegPd, vcoPd, oscPd}, 16'h000A);
		check({frPd, syncAvail}, 16'h0001);
		check({frDlyPd, plsPd}, 16'h0000);
		wr(`OFF_DYN_ENABLES, 8'hA5);
		check({frDynEn, outDynEn}, 16'h00A5);
		// bursts of every length code
		srcSel = 2'h2;
		syncMode = `SYNC_MODE_ON_WRITE;
		for (int c = 0; c < 4; c++) begin
			clrCnt = 1'b1;
			@(negedge clk);
			wr(`OFF_BURST_LENGTH, 8'(c));
			// eight pulses of four high cycles outlast the write's tail
			if (c == 3) check(burstActive, 16'h0001);
			settle();
			check(pulseRises, 16'(1 << c));
			check(pulseHighs,
				16'((1 << c) * `PULSE_HIGH_CYCLES));
		end
		// continuous source, frame ref off, pulser off: no pulses
		for (int k = 0; k < 3; k++) begin
			srcSel = badSrc[k];
			wr(`OFF_POWER_DOWN, badPd[k]);
			clrCnt = 1'b1;
			@(negedge clk);
			wr(`OFF_BURST_LENGTH, 8'h03);
			settle();
			check(pulseRises, 16'h0000);
		end
		// delay step counts of zero, one and fifteen
		for (int k = 0; k < 3; k++) begin
			clrCnt = 1'b1;
			@(negedge clk);
			wr(`OFF_DYN_STEPS, {4'h0, stepTab[k]});
			// one step delivered, the gap before the second still running
			if (k == 2) check(stepsLeft, 16'h000E);
			settle();
			check(stepCount, 16'(stepTab[k]));
			if (stepTab[k] != 4'h0) check(dynTargets, 16'h00A5);
		end
		giveVerdict();
	end
endmodule

`default_nettype wire
